//--- psc_top.sv
// Purpose: strap loader and management register map of the transceiver
// Assumes: strap and address pins are asynchronous and settle before rst falls
// Notes: control bit 15 reloads straps as a reset does
//
// What this block does
// R1: straps sampled at reset only seed registers; later management writes rule them
// R2: with autoneg on, strap pair and duplex strap seed advertisement bits 8..5
// R3: autoneg strap low leaves advertisement bits 8..5 at defaults
// R4: each address pin sampled low gives active-high LED, high gives active-low
// R5: five sampled address pins form the address; only matching frames answered
// R6: sampled address zero starts the device isolated, management still reachable
// R7: eleven 16-bit registers at indices 0 to 6 and 17 to 20
// R8: each multi-function strap seeds one control or coding bit
// R9: with autoneg off, duplex strap sets or clears the duplex select bit
// R10: unimplemented indices read zero and ignore writes
`timescale 1ns/1ns
`default_nettype none
module psc_top
	import psc_pkg::*;
#(
	parameter logic [15:0] ID_HIGH = 16'h1234,
	parameter logic [15:0] ID_LOW  = 16'h5670,
	parameter int          LED_N   = 5
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [4:0]  multi_function_straps,
	input  wire logic [1:0]  adv_pair_straps,
	input  wire logic        full_duplex_strap,
	input  wire logic [4:0]  led_addr_pins,
	input  wire logic [4:0]  led_on,
	input  wire logic        link_up,
	input  wire logic        an_complete,
	input  wire logic [15:0] partner_ability_in,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe,
	output logic      [4:0]  led_out,
	output logic             cfg_ready,
	output logic             isolate,
	output logic             power_down,
	output logic             loopback,
	output logic             speed_100,
	output logic             autoneg_en,
	output logic             full_duplex,
	output logic             coll_test,
	output logic             an_restart,
	output logic             nrzi_en,
	output logic             coding_en,
	output logic             scrambler_dis
);
	typedef struct packed {
		psc_ld_e     st;
		logic [2:0]  cnt;
		logic [4:0]  ms1;
		logic [4:0]  ms2;
		logic [1:0]  cf1;
		logic [1:0]  cf2;
		logic        fd1;
		logic        fd2;
		logic [4:0]  pa1;
		logic [4:0]  pa2;
		logic [4:0]  smp_ms;
		logic [1:0]  smp_cf;
		logic        smp_fd;
		logic [4:0]  phy;
		logic [4:0]  pol;
		logic [15:0] ctl;
		logic [15:0] adv;
		logic [15:0] fst;
		logic [15:0] ien;
		logic [15:0] mode;
		logic [4:0]  led;
		logic        anr;
	} psc_top_s;

	psc_top_s    q;
	psc_top_s    d;
	logic [4:0]  reg_addr;
	logic        wr_stb;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic        load_done;

	if (LED_N != 5)
		$error("LED and address pins are fixed at five");

	function automatic logic is_impl(input logic [4:0] a);
		case (a)
			A_CTRL, A_STAT, A_IDHI, A_IDLO, A_ADV, A_LPA, A_EXP,
			A_CFG, A_IEN, A_FAST, A_MODE:
				is_impl = 1'b1;
			default:
				is_impl = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [15:0] m);
		merge = (o & ~m) | (n & m);
	endfunction

	psc_mdio u_mdio
	(
		.ref_clk  (ref_clk),
		.rst      (rst),
		.mdc      (mdc),
		.mdio_in  (mdio_in),
		.phy_addr (q.phy),
		.rd_data  (rd_data),
		.reg_addr (reg_addr),
		.wr_stb   (wr_stb),
		.wr_data  (wr_data),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe)
	);

	assign load_done = (q.st == LD_WAIT) && (q.cnt == LOAD_CYC);

	// read mux; link inputs show live in the status word, the sampled address in the config word
	always_comb
	begin
		rd_data = 16'h0000;
		case (reg_addr)
			A_CTRL: rd_data = q.ctl;
			A_STAT:
			begin
				rd_data = STA_CAP;
				rd_data[STA_LINK] = link_up;
				rd_data[STA_ANOK] = an_complete;
			end
			A_IDHI: rd_data = ID_HIGH;
			A_IDLO: rd_data = ID_LOW;
			A_ADV: rd_data = q.adv;
			A_LPA: rd_data = partner_ability_in;
			A_EXP: rd_data = 16'h0000;
			A_CFG: rd_data = {11'h000, q.phy};
			A_IEN: rd_data = q.ien;
			A_FAST: rd_data = q.fst;
			A_MODE: rd_data = q.mode;
			default: rd_data = 16'h0000; // see R10
		endcase
	end

	always_comb
	begin
		d = q;
		d.ms1 = multi_function_straps;
		d.ms2 = q.ms1;
		d.cf1 = adv_pair_straps;
		d.cf2 = q.cf1;
		d.fd1 = full_duplex_strap;
		d.fd2 = q.fd1;
		d.pa1 = led_addr_pins;
		d.pa2 = q.pa1;
		d.anr = 1'b0;
		d.ctl[CTL_RSAN] = 1'b0;
		d.led = led_on ^ q.pol; // see R4
		case (q.st)
			LD_WAIT:
			begin
				// lamps dark at the pin level while loading; a stale polarity would light them
				d.led = q.pa2;
				d.cnt = q.cnt + 3'h1;
				// wait lets the pin synchronisers flush after reset release
				if (q.cnt == LOAD_CYC)
				begin
					d.st = LD_RUN;
					d.cnt = 3'h0;
					d.smp_ms = q.ms2;
					d.smp_cf = q.cf2;
					d.smp_fd = q.fd2;
					d.phy = q.pa2; // see R5
					d.pol = q.pa2; // see R4
					// lamps take the new polarity in the same cycle as cfg_ready
					d.led = led_on ^ q.pa2; // see R4
					d.ctl = CTL_RV; // see R1
					d.ctl[CTL_SPD] = q.ms2[SP_SPD]; // see R8
					d.ctl[CTL_AN] = q.ms2[SP_AN]; // see R8
					d.ctl[CTL_ISO] = (q.pa2 == 5'h00); // see R6
					d.ctl[CTL_DPX] = !q.ms2[SP_AN] && q.fd2; // see R9
					d.adv = ADV_RV; // see R3
					if (q.ms2[SP_AN])
					begin
						d.adv[ADV_H100] = q.cf2[0]; // see R2
						d.adv[ADV_H10] = q.cf2[1]; // see R2
						d.adv[ADV_F100] = q.cf2[0] && q.fd2; // see R2
						d.adv[ADV_F10] = q.cf2[1] && q.fd2; // see R2
					end
					d.fst = FST_RV;
					d.fst[FST_NRZI] = q.ms2[SP_NRZI]; // see R8
					d.fst[FST_CODE] = q.ms2[SP_CODE]; // see R8
					d.fst[FST_SCR] = q.ms2[SP_SCR]; // see R8
					d.ien = 16'h0000;
					d.mode = 16'h0000;
				end
			end
			LD_RUN:
			begin
				// after seeding only management writes move these
				if (wr_stb && is_impl(reg_addr)) // see R1
				begin
					case (reg_addr)
						A_CTRL:
						begin
							d.ctl = merge(q.ctl, wr_data, CTL_WM); // see R7
							d.anr = wr_data[CTL_RSAN];
							if (wr_data[CTL_RST])
							begin
								d.st = LD_WAIT;
								d.cnt = 3'h0;
							end
						end
						A_ADV: d.adv = merge(q.adv, wr_data, ADV_WM); // see R7
						A_IEN: d.ien = wr_data; // see R7
						A_FAST: d.fst = merge(q.fst, wr_data, FST_WM); // see R7
						A_MODE: d.mode = wr_data; // see R7
						default: d.anr = 1'b0;
					endcase
				end
			end
			default:
				d.st = LD_WAIT;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			q <= '{st: LD_WAIT, ctl: CTL_RV, adv: ADV_RV, fst: FST_RV, default: '0};
		else
			q <= d;
	end

	assign led_out = q.led;
	assign cfg_ready = (q.st == LD_RUN);
	assign isolate = q.ctl[CTL_ISO];
	assign power_down = q.ctl[CTL_PD];
	assign loopback = q.ctl[CTL_LOOP];
	assign speed_100 = q.ctl[CTL_SPD];
	assign autoneg_en = q.ctl[CTL_AN];
	assign full_duplex = q.ctl[CTL_DPX];
	assign coll_test = q.ctl[CTL_COLT];
	assign an_restart = q.anr;
	assign nrzi_en = q.fst[FST_NRZI];
	assign coding_en = q.fst[FST_CODE];
	assign scrambler_dis = q.fst[FST_SCR];

	property p_no_strap_after;
		@(posedge ref_clk) disable iff (rst)
		(q.st == LD_RUN && !wr_stb) |=> ($stable(q.ctl[14:10]) && $stable(q.adv) && $stable(q.fst));
	endproperty
	a_no_strap_after: assert property (p_no_strap_after) // see R1
		else $error("registers moved without a management write");

	property p_adv_seed;
		@(posedge ref_clk) disable iff (rst)
		(load_done && q.ms2[SP_AN]) |=> (q.adv[ADV_H100] == q.smp_cf[0] && q.adv[ADV_H10] == q.smp_cf[1]
			&& q.adv[ADV_F100] == (q.smp_cf[0] && q.smp_fd) && q.adv[ADV_F10] == (q.smp_cf[1] && q.smp_fd));
	endproperty
	a_adv_seed: assert property (p_adv_seed) // see R2
		else $error("advertisement not seeded from straps");

	property p_adv_default;
		@(posedge ref_clk) disable iff (rst)
		(load_done && !q.ms2[SP_AN]) |=> (q.adv[8:5] == ADV_RV[8:5]);
	endproperty
	a_adv_default: assert property (p_adv_default) // see R3
		else $error("advertisement not at default with autoneg off");

	property p_led_pol;
		@(posedge ref_clk) disable iff (rst)
		(q.st == LD_RUN) ##1 (q.st == LD_RUN) |-> (q.led == ($past(led_on) ^ q.pol));
	endproperty
	a_led_pol: assert property (p_led_pol) // see R4
		else $error("lamp polarity differs from sampled pin");

	property p_addr_seed;
		@(posedge ref_clk) disable iff (rst)
		load_done |=> (q.phy == q.pol && q.phy == $past(q.pa2));
	endproperty
	a_addr_seed: assert property (p_addr_seed) // see R5
		else $error("address not taken from pins");

	property p_iso_zero;
		@(posedge ref_clk) disable iff (rst)
		load_done |=> (q.ctl[CTL_ISO] == (q.phy == 5'h00)) ##1 (isolate == (q.phy == 5'h00) || $past(wr_stb));
	endproperty
	a_iso_zero: assert property (p_iso_zero) // see R6
		else $error("isolation does not follow address zero");

	property p_write_lands;
		@(posedge ref_clk) disable iff (rst)
		(q.st == LD_RUN && wr_stb && reg_addr == A_MODE) |=> (q.mode == $past(wr_data));
	endproperty
	a_write_lands: assert property (p_write_lands) // see R7
		else $error("write to mode register lost");

	property p_strap_seed;
		@(posedge ref_clk) disable iff (rst)
		load_done |=> (q.ctl[CTL_AN] == q.smp_ms[SP_AN] && q.ctl[CTL_SPD] == q.smp_ms[SP_SPD]
			&& q.fst[FST_NRZI] == q.smp_ms[SP_NRZI] && q.fst[FST_CODE] == q.smp_ms[SP_CODE]
			&& q.fst[FST_SCR] == q.smp_ms[SP_SCR]);
	endproperty
	a_strap_seed: assert property (p_strap_seed) // see R8
		else $error("control bits not seeded from multi-function straps");

	property p_dpx_seed;
		@(posedge ref_clk) disable iff (rst)
		load_done |=> (q.ctl[CTL_DPX] == (!q.smp_ms[SP_AN] && q.smp_fd));
	endproperty
	a_dpx_seed: assert property (p_dpx_seed) // see R9
		else $error("duplex select not seeded from strap");

	property p_hole_zero;
		@(posedge ref_clk) disable iff (rst)
		!is_impl(reg_addr) |-> (rd_data == 16'h0000);
	endproperty
	a_hole_zero: assert property (p_hole_zero) // see R10
		else $error("unimplemented index reads nonzero");
endmodule
`default_nettype wire

//--- psc_pkg.sv
// Purpose: shared constants and types of the strap loader and management map
// Assumes: 5-bit management register index, 16-bit registers
// Notes: reset values below are the seeds before any strap is applied
package psc_pkg;
	localparam logic [4:0] A_CTRL = 5'h00;
	localparam logic [4:0] A_STAT = 5'h01;
	localparam logic [4:0] A_IDHI = 5'h02;
	localparam logic [4:0] A_IDLO = 5'h03;
	localparam logic [4:0] A_ADV  = 5'h04;
	localparam logic [4:0] A_LPA  = 5'h05;
	localparam logic [4:0] A_EXP  = 5'h06;
	localparam logic [4:0] A_CFG  = 5'h11;
	localparam logic [4:0] A_IEN  = 5'h12;
	localparam logic [4:0] A_FAST = 5'h13;
	localparam logic [4:0] A_MODE = 5'h14;
	localparam int CTL_RST  = 15;
	localparam int CTL_LOOP = 14;
	localparam int CTL_SPD  = 13;
	localparam int CTL_AN   = 12;
	localparam int CTL_PD   = 11;
	localparam int CTL_ISO  = 10;
	localparam int CTL_RSAN = 9;
	localparam int CTL_DPX  = 8;
	localparam int CTL_COLT = 7;
	localparam int ADV_F100 = 8;
	localparam int ADV_H100 = 7;
	localparam int ADV_F10  = 6;
	localparam int ADV_H10  = 5;
	localparam int FST_NRZI = 7;
	localparam int FST_CODE = 6;
	localparam int FST_SCR  = 0;
	localparam int STA_LINK = 2;
	localparam int STA_ANOK = 5;
	localparam int SP_AN    = 0;
	localparam int SP_NRZI  = 1;
	localparam int SP_CODE  = 2;
	localparam int SP_SCR   = 3;
	localparam int SP_SPD   = 4;
	localparam logic [15:0] CTL_RV  = 16'h3000;
	localparam logic [15:0] ADV_RV  = 16'h01E1;
	localparam logic [15:0] FST_RV  = 16'h00C0;
	localparam logic [15:0] STA_CAP = 16'h7808;
	localparam logic [15:0] CTL_WM  = 16'hFF80;
	localparam logic [15:0] ADV_WM  = 16'hFFE0;
	localparam logic [15:0] FST_WM  = 16'h00C1;
	localparam logic [2:0]  LOAD_CYC = 3'h3;
	localparam int PRE_ONES = 32;
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [4:0] HDR_LAST = 5'h0C;
	localparam logic [4:0] DAT_LAST = 5'h0F;
	typedef enum logic {LD_WAIT, LD_RUN} psc_ld_e;
	typedef enum logic [1:0] {MD_IDLE, MD_HDR, MD_TA, MD_DATA} psc_md_e;
endpackage

//--- psc_mdio.sv
// Purpose: serial management frame engine, read and write of one register
// Assumes: mdc far slower than ref_clk; both pins oversampled
// Notes: output changes one sync delay after the mdc rising edge
`timescale 1ns/1ns
`default_nettype none
module psc_mdio
	import psc_pkg::*;
#(
	parameter int PRE_LEN = PRE_ONES
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	input  wire logic [4:0]  phy_addr,
	input  wire logic [15:0] rd_data,
	output logic      [4:0]  reg_addr,
	output logic             wr_stb,
	output logic      [15:0] wr_data,
	output logic             mdio_out,
	output logic             mdio_oe
);
	typedef struct packed {
		psc_md_e     st;
		logic        c1;
		logic        c2;
		logic        c3;
		logic        i1;
		logic        i2;
		logic [5:0]  ones;
		logic [4:0]  cnt;
		logic [15:0] sh;
		logic        rd;
		logic [4:0]  fphy;
		logic [4:0]  addr;
		logic        wr;
		logic        oe;
		logic        out;
	} psc_md_s;

	psc_md_s q;
	psc_md_s d;
	logic [12:0] hdr;

	if (PRE_LEN < 1 || PRE_LEN > 63)
		$error("preamble length out of range");

	assign hdr = {q.sh[11:0], q.i2};

	always_comb
	begin
		d = q;
		d.c1 = mdc;
		d.c2 = q.c1;
		d.c3 = q.c2;
		d.i1 = mdio_in;
		d.i2 = q.i1;
		d.wr = 1'b0;
		if (q.c2 && !q.c3)
		begin
			d.cnt = q.cnt + 5'h01;
			case (q.st)
				MD_IDLE:
				begin
					if (q.i2)
						d.ones = (q.ones == 6'h3F) ? q.ones : q.ones + 6'h01;
					else
					begin
						if (q.ones >= 6'(PRE_LEN))
							d.st = MD_HDR;
						d.ones = 6'h00;
						d.cnt = 5'h00;
					end
				end
				MD_HDR:
				begin
					d.sh = {q.sh[14:0], q.i2};
					if (q.cnt == HDR_LAST)
					begin
						d.cnt = 5'h00;
						d.rd = (hdr[11:10] == OP_RD);
						d.fphy = hdr[9:5];
						d.addr = hdr[4:0];
						// foreign addresses drop back to idle, sharing the bus
						if (hdr[12] && (hdr[11:10] == OP_RD || hdr[11:10] == OP_WR) && hdr[9:5] == phy_addr) // see R5
							d.st = MD_TA;
						else
							d.st = MD_IDLE;
					end
				end
				MD_TA:
				begin
					if (q.cnt == 5'h00)
					begin
						d.oe = q.rd;
						d.out = 1'b0;
					end
					else
					begin
						d.st = MD_DATA;
						d.cnt = 5'h00;
						if (q.rd)
						begin
							d.out = rd_data[15];
							d.sh = {rd_data[14:0], 1'b0};
						end
					end
				end
				MD_DATA:
				begin
					if (q.rd)
					begin
						d.out = q.sh[15];
						d.sh = {q.sh[14:0], 1'b0};
					end
					else
						d.sh = {q.sh[14:0], q.i2};
					if (q.cnt == DAT_LAST)
					begin
						d.oe = 1'b0;
						d.wr = !q.rd;
						d.st = MD_IDLE;
					end
				end
				default:
					d.st = MD_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			q <= '{st: MD_IDLE, default: '0};
		else
			q <= d;
	end

	assign reg_addr = q.addr;
	assign wr_stb = q.wr;
	assign wr_data = q.sh;
	assign mdio_out = q.out;
	assign mdio_oe = q.oe;

	property p_drive_own;
		@(posedge ref_clk) disable iff (rst)
		$rose(q.oe) |-> (q.fphy == phy_addr && q.rd);
	endproperty
	a_drive_own: assert property (p_drive_own) // see R5
		else $error("read answered for a foreign address");
endmodule
`default_nettype wire

//--- psc_sta_model.sv
// Purpose: station manager that runs management frames
// Assumes: the shared wire is pulled up when nobody drives
// Notes: mdc rests low between frames; read data taken at mdc rise
`timescale 1ns/1ns
`default_nettype none
module psc_sta_model (
	input  wire logic ref_clk,
	input  wire logic mdio_out,
	input  wire logic mdio_oe,
	output logic      mdc,
	output logic      mdio_in
);
	logic drv;
	logic en;

	initial
	begin
		mdc = 1'b0;
		drv = 1'b1;
		en = 1'b0;
	end

	// pull-up wins once both sides let go
	assign mdio_in = mdio_oe ? mdio_out : (en ? drv : 1'b1);

	// five ref_clk low, five high: above the four-cycle floor of the sync path
	task automatic clk_bit(input logic b, input logic e, output logic s);
		@(posedge ref_clk);
		drv <= b;
		en <= e;
		repeat (4) @(posedge ref_clk);
		mdc <= 1'b1;
		s = mdio_in;
		repeat (5) @(posedge ref_clk);
		mdc <= 1'b0;
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd, output logic ta);
		logic [13:0] hdr;
		logic        s;
		logic        wop;
		hdr = {2'b01, op, pa, ra};
		wop = (op != 2'h2);
		for (int i = 0; i < 32; i++)
			clk_bit(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--)
			clk_bit(hdr[i], 1'b1, s);
		clk_bit(1'b1, wop, s);
		clk_bit(1'b0, wop, ta);
		for (int i = 15; i >= 0; i--)
		begin
			clk_bit(wd[i], wop, s);
			rd[i] = s;
		end
		en <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- tb_phy_strap_config_and_regmap.sv
// Purpose: strap seeding and management map checks
// Assumes: frames start only after cfg_ready
// Notes: each strap case costs a reset and two frames
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_phy_strap_config_and_regmap
	import psc_pkg::*;
;
	logic        ref_clk, rst, fd_strap, link_up, an_complete, mdc, mdio_in, mdio_out, mdio_oe, cfg_ready;
	logic        isolate, power_down, loopback, speed_100, autoneg_en, full_duplex, coll_test;
	logic        an_restart, nrzi_en, coding_en, scrambler_dis, t;
	logic [1:0]  pair;
	logic [4:0]  mstrap, pins, led_on, led_out;
	logic [15:0] pa_in, v;
	int          failures, check_count, cyc, rs_cnt;
	logic [4:0]  ro_a [8] = '{A_STAT, A_IDHI, A_IDLO, A_LPA, A_EXP, 5'h07, 5'h10, 5'h15};
	logic [15:0] ro_v [8] = '{STA_CAP | 16'h0024, 16'hA5C3, 16'h0F10, 16'h4DE1, 16'h0000, 16'h0000,
		16'h0000, 16'h0000};

	// id values are arbitrary
	psc_top #(.ID_HIGH(16'hA5C3), .ID_LOW(16'h0F10)) dut (
		.ref_clk, .rst, .multi_function_straps(mstrap), .adv_pair_straps(pair), .full_duplex_strap(fd_strap),
		.led_addr_pins(pins), .led_on, .link_up, .an_complete, .partner_ability_in(pa_in), .mdc,
		.mdio_in, .mdio_out, .mdio_oe, .led_out, .cfg_ready, .isolate, .power_down, .loopback,
		.speed_100, .autoneg_en, .full_duplex, .coll_test, .an_restart, .nrzi_en, .coding_en, .scrambler_dis
	);

	psc_sta_model sta (.ref_clk, .mdio_out, .mdio_oe, .mdc, .mdio_in);

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// roughly fifty frames of 640 cycles each
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (an_restart === 1'b1)
			rs_cnt <= rs_cnt + 1;
		if (cyc == 60000)
		begin
			failures++;
			conclude();
		end
	end

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] x;
		logic        y;
		sta.frame(OP_WR, pins, ra, d, x, y);
	endtask

	task automatic rd(input logic [4:0] ra, output logic [15:0] d);
		logic y;
		sta.frame(OP_RD, pins, ra, 16'h0000, d, y);
	endtask

	task automatic cfg_check(input logic [4:0] m, input logic [1:0] p, input logic f, input logic [4:0] a);
		logic [15:0] r;
		logic [3:0]  b;
		@(posedge ref_clk);
		mstrap <= m;
		pair <= p;
		fd_strap <= f;
		pins <= a;
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 20 && cfg_ready !== 1'b1; i++)
			@(negedge ref_clk);
		b = m[0] ? {p[0] & f, p[0], p[1] & f, p[1]} : ADV_RV[8:5];
		`CHK("ready", 1'b1, cfg_ready)
		`CHK("ctl", m, {speed_100, scrambler_dis, coding_en, nrzi_en, autoneg_en})
		`CHK("dpx", !m[0] & f, full_duplex)
		`CHK("iso", (a == 5'h00), isolate)
		`CHK("led", led_on ^ a, led_out)
		rd(A_ADV, r);
		`CHK("adv", {ADV_RV[15:9], b, ADV_RV[4:0]}, r)
		rd(A_CFG, r);
		`CHK("addr", {11'h000, a}, r)
	endtask

	initial
	begin
		rst = 1'b1;
		mstrap = 5'h00;
		pair = 2'h0;
		fd_strap = 1'b0;
		pins = 5'h01;
		led_on = 5'h16;
		link_up = 1'b1;
		an_complete = 1'b1;
		pa_in = 16'h4DE1;
		cfg_check(5'h1E, 2'b11, 1'b1, 5'h0C);
		cfg_check(5'h06, 2'b01, 1'b0, 5'h11);
		cfg_check(5'h01, 2'b01, 1'b0, 5'h15);
		cfg_check(5'h11, 2'b01, 1'b1, 5'h1F);
		cfg_check(5'h09, 2'b10, 1'b0, 5'h00);
		cfg_check(5'h0F, 2'b10, 1'b1, 5'h03);
		cfg_check(5'h05, 2'b11, 1'b0, 5'h10);
		cfg_check(5'h01, 2'b00, 1'b1, 5'h07);
		cfg_check(5'h17, 2'b11, 1'b1, 5'h0A);
		// straps moved after reset only count at the next load
		mstrap <= 5'h08;
		fd_strap <= 1'b0;
		wr(A_ADV, 16'h8140);
		rd(A_ADV, v);
		`CHK("advw", 16'h8141, v)
		`CHK("anhold", 2'b10, {autoneg_en, scrambler_dis})
		wr(A_CTRL, 16'h417F);
		rd(A_CTRL, v);
		`CHK("ctlw", 16'h4100, v)
		`CHK("ctlo", 4'b1100, {loopback, full_duplex, autoneg_en, speed_100})
		wr(A_CTRL, 16'h3A80);
		rd(A_CTRL, v);
		`CHK("ctlw2", 16'h3880, v)
		`CHK("pdct", 2'b11, {power_down, coll_test})
		`CHK("rsan", 1, rs_cnt)
		wr(A_FAST, 16'hFF01);
		rd(A_FAST, v);
		`CHK("fast", 16'h0001, v)
		`CHK("fasto", 3'b001, {nrzi_en, coding_en, scrambler_dis})
		wr(A_IEN, 16'hA55A);
		wr(A_MODE, 16'h3CC3);
		rd(A_MODE, v);
		`CHK("mode", 16'h3CC3, v)
		foreach (ro_a[i])
		begin
			wr(ro_a[i], 16'hFFFF);
			rd(ro_a[i], v);
			`CHK("ro", ro_v[i], v)
		end
		// a foreign address must leave the wire to the pull-up
		sta.frame(OP_RD, pins ^ 5'h01, A_IEN, 16'h0000, v, t);
		`CHK("frgr", 17'h1FFFF, {t, v})
		sta.frame(OP_WR, pins ^ 5'h10, A_IEN, 16'h0000, v, t);
		sta.frame(OP_RD, pins, A_IEN, 16'h0000, v, t);
		`CHK("frgw", 17'h0A55A, {t, v})
		wr(A_CTRL, 16'h8000);
		rd(A_CTRL, v);
		`CHK("rld", 16'h0000, v)
		rd(A_ADV, v);
		`CHK("rldadv", ADV_RV, v)
		rd(A_FAST, v);
		`CHK("rldfst", 16'h0001, v)
		conclude();
	end
endmodule
`default_nettype wire
